// [verif/multi_port_digital_io_sva.sv]
// assertion checker for the five-port digital io block
module multi_port_digital_io_sva
    import gpio_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_out,
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_oe_n,
    input wire logic irq_p0_pin0,
    input wire logic irq_p1,
    input wire logic irq_p2,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic dp_q;
    logic dp_wr_q;
    idx_t dp_idx_q;
    // data phase of the transfer taken at the last edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dp_q <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_idx_q <= 8'h00;
        end else begin
            dp_q <= hsel && htrans[1] && hready;
            dp_wr_q <= hwrite;
            dp_idx_q <= haddr[ADDR_MSB:ADDR_LSB];
        end
    end
    function automatic logic wr_hit(input idx_t idx);
        return dp_q && dp_wr_q && dp_idx_q == idx;
    endfunction : wr_hit
    sequence wr_to(idx_t idx);
        dp_q && dp_wr_q && dp_idx_q == idx;
    endsequence
    bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY) else $error("bus not ready or not okay");
    hrdata_idle_a: assert property (!(dp_q && !dp_wr_q) |-> hrdata == 32'h0) else $error("read data outside read");
    dir_oe_a: assert property (wr_to(DIR_IDX[0]) |=> pin_oe_n[0] == ~$past(hwdata[7:0])) else $error("oe not dir");
    out_drive_a: assert property (wr_to(OUT_IDX[0]) |=> pin_out[0] == $past(hwdata[7:0])) else $error("out not driven");
    irq_sticky_a: assert property (irq_p1 && !wr_hit(IFG_IDX[1]) && !wr_hit(IE_IDX[1]) |=> irq_p1)
        else $error("request dropped");
    ie_block_a: assert property (wr_to(IE_IDX[2]) and hwdata[7:0] == 8'h00 |=> !irq_p2) else $error("masked request");
    sfa_block_a: assert property (wr_to(SFA_IE_IDX) and !hwdata[SFA_P0_LSB] |=> !irq_p0_pin0)
        else $error("pin0 request masked");
    irq_or_a: assert property ((irq_p0_pin0 || irq_p1 || irq_p2) |-> irq) else $error("summary request low");
endmodule : multi_port_digital_io_sva
bind multi_port_digital_io multi_port_digital_io_sva i_multi_port_digital_io_sva (.*);

// [verif/pin_board.sv]
// board model of the port pins
module pin_board
    import gpio_pkg::*;
(
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_out,
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_oe_n,
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] ext_level,
    output logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // driven pins show the block's value, the rest the board level
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : pin_board

// [verif/tb_top.sv]
// self-checking bench for the five-port digital io block
module tb_top import gpio_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, irq_p0_pin0, irq_p0_pin1, irq_p0_shared, irq_p1, irq_p2, irq;
    logic [31:0] hrdata, rd;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in, pin_out, pin_oe_n, periph_in;
    logic [NUM_PORTS-1:0][PORT_W-1:0] periph_out = '0, periph_drive = '0, ext_level = '0;
    int mismatches = 0;
    int tests_run = 0;
    port_t v, d, e;
    always #5 clk = ~clk;
    multi_port_digital_io i_multi_port_digital_io (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_in, .pin_out, .pin_oe_n, .periph_out,
        .periph_drive, .periph_in, .irq_p0_pin0, .irq_p0_pin1, .irq_p0_shared, .irq_p1, .irq_p2, .irq);
    pin_board i_pin_board (.pin_out, .pin_oe_n, .ext_level, .pin_in);
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            mismatches++;
            wrap_up();
        end
    endtask : edge_ready
    // one single transfer; an idle cycle lies between it and the next call
    task automatic xfer(input idx_t idx, input logic wr, input port_t wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        edge_ready();
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= {24'h0, wd};
        edge_ready();
        rd = hrdata;
    endtask : xfer
    task automatic rd_chk(input string what, input idx_t idx, input port_t exp);
        xfer(idx, 1'b0, 8'h00);
        check(what, {24'h0, exp}, rd);
    endtask : rd_chk
    function automatic logic [31:0] exp_lines(input int q);
        return (q == 0) ? 32'h1c : 32'h1 << (2 - q);
    endfunction : exp_lines
    initial begin
        void'($urandom(32'h1047a879));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        rd_chk("unmapped", 8'h3f, 8'h00);
        for (int p = 0; p < NUM_PORTS; p++) begin
            v = port_t'($urandom);
            d = port_t'($urandom);
            ext_level[p] <= port_t'($urandom);
            rd_chk("dir reset", DIR_IDX[p], REG_RESET);
            xfer(OUT_IDX[p], 1'b1, v);
            xfer(DIR_IDX[p], 1'b1, d);
            repeat (4) @(posedge clk);
            check("pin_out", {24'h0, v}, {24'h0, pin_out[p]});
            check("pin_oe_n", {24'h0, ~d}, {24'h0, pin_oe_n[p]});
            check("periph_in", {24'h0, (d & v) | (~d & ext_level[p])}, {24'h0, periph_in[p]});
            rd_chk("in", IN_IDX[p], (d & v) | (~d & ext_level[p]));
            rd_chk("out", OUT_IDX[p], v);
            if (p > 0) begin
                periph_out[p] <= port_t'($urandom);
                periph_drive[p] <= port_t'($urandom);
                xfer(SEL_IDX[p], 1'b1, 8'hff);
                @(posedge clk);
                check("periph out", {24'h0, periph_out[p]}, {24'h0, pin_out[p]});
                check("periph oe", {24'h0, ~periph_drive[p]}, {24'h0, pin_oe_n[p]});
                xfer(SEL_IDX[p], 1'b1, 8'h00);
            end
        end
        $display("test ports done");
        for (int q = 0; q < IRQ_PORTS; q++) begin
            e = port_t'($urandom);
            xfer(DIR_IDX[q], 1'b1, 8'h00);
            ext_level[q] <= e;
            xfer(IES_IDX[q], 1'b1, e);
            xfer(IE_IDX[q], 1'b1, 8'hff);
            xfer(SFA_IE_IDX, 1'b1, 8'h0c);
            repeat (5) @(posedge clk);
            xfer(IFG_IDX[q], 1'b1, 8'hff);
            xfer(SFA_IFG_IDX, 1'b1, 8'h0c);
            ext_level[q] <= ~e;
            repeat (5) @(posedge clk);
            check("irq", 32'h1, {31'h0, irq});
            check("irq lines", exp_lines(q), {27'h0, irq_p0_pin0, irq_p0_pin1, irq_p0_shared, irq_p1, irq_p2});
            rd_chk("flag", IFG_IDX[q], OWN_MASK[q]);
            rd_chk("area flag", SFA_IFG_IDX, (q == 0) ? 8'h0c : 8'h00);
            xfer(IE_IDX[q], 1'b1, 8'h00);
            xfer(SFA_IE_IDX, 1'b1, 8'h00);
            @(posedge clk);
            check("masked irq", 32'h0, {31'h0, irq});
            rd_chk("flag kept", IFG_IDX[q], OWN_MASK[q]);
            xfer(IFG_IDX[q], 1'b1, 8'hff);
            xfer(SFA_IFG_IDX, 1'b1, 8'h0c);
            ext_level[q] <= e;
            repeat (5) @(posedge clk);
            rd_chk("no flag", IFG_IDX[q], 8'h00);
        end
        $display("test interrupts done");
        wrap_up();
    end
endmodule : tb_top

// [verilog/gpio_pkg.sv]
// constants, register indices and types for the five-port digital io block
package gpio_pkg;
    localparam int NUM_PORTS = 5;
    localparam int PORT_W = 8;
    localparam int IRQ_PORTS = 3;
    typedef logic [7:0] idx_t;
    typedef logic [PORT_W-1:0] port_t;
    // byte address = 4 * register index
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 9;
    // special function area: enable and flag bits of port_zero pins 0 and 1
    localparam idx_t SFA_IE_IDX = 8'h00;
    localparam idx_t SFA_IFG_IDX = 8'h02;
    localparam int SFA_P0_LSB = 2;
    localparam int SFA_P0_MSB = 3;
    // per port register indices: port_zero .. port_four
    localparam idx_t IN_IDX [NUM_PORTS] = '{8'h10, 8'h20, 8'h28, 8'h18, 8'h1c};
    localparam idx_t OUT_IDX [NUM_PORTS] = '{8'h11, 8'h21, 8'h29, 8'h19, 8'h1d};
    localparam idx_t DIR_IDX [NUM_PORTS] = '{8'h12, 8'h22, 8'h2a, 8'h1a, 8'h1e};
    localparam idx_t SEL_IDX [NUM_PORTS] = '{8'h16, 8'h26, 8'h2e, 8'h1b, 8'h1f};
    localparam logic [NUM_PORTS-1:0] SEL_PRESENT = 5'h1e;
    localparam idx_t IFG_IDX [IRQ_PORTS] = '{8'h13, 8'h23, 8'h2b};
    localparam idx_t IES_IDX [IRQ_PORTS] = '{8'h14, 8'h24, 8'h2c};
    localparam idx_t IE_IDX [IRQ_PORTS] = '{8'h15, 8'h25, 8'h2d};
    // bits held by each port's own flag and enable registers
    localparam port_t OWN_MASK [IRQ_PORTS] = '{8'hfc, 8'hff, 8'hff};
    localparam port_t REG_RESET = 8'h00;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
    localparam int PRIME_W = 3;
endpackage : gpio_pkg

// [verilog/multi_port_digital_io.sv]
// five-port digital io block with edge interrupts behind an ahb-lite slave
// What this block does
// - five independent eight-bit ports, numbered zero to four.
// - port zero six registers, ports one and two seven, ports three and four four.
// - every pin bit configured on its own, any mix per port.
// - ports zero, one, two detect interrupts on all eight bits; three, four none.
// - every port register reachable by bus reads, and by writes except the input register.
// - input register reads the levels sampled at the pins.
// - output register holds the value driven on output pins.
// - direction bit picks input or driven output per pin.
// - edge-select bit picks which transition raises the event.
// - flag bit shows an event pending on its pin.
// - enable bit lets or blocks a pin's interrupt request.
// - function-select bit hands the pin to another peripheral.
// - registers eight bits, except port zero flag and enable, six bits.
// - port zero pins zero and one flag and enable live in special function area.
// - five requests: port zero pin zero, pin one, pins two-seven, port one, port two.
// - special function area enable bits sit at the lowest addresses.
module multi_port_digital_io
    import gpio_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in,
    output logic [NUM_PORTS-1:0][PORT_W-1:0] pin_out,
    output logic [NUM_PORTS-1:0][PORT_W-1:0] pin_oe_n,
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] periph_out,
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] periph_drive,
    output logic [NUM_PORTS-1:0][PORT_W-1:0] periph_in,
    output logic irq_p0_pin0,
    output logic irq_p0_pin1,
    output logic irq_p0_shared,
    output logic irq_p1,
    output logic irq_p2,
    output logic irq
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic wr_pend_q;
    logic rd_pend_q;
    idx_t addr_q;
    port_t wdata;
    port_t rd_byte;
    logic [PRIME_W-1:0] prime_q;
    port_t sync1_q [NUM_PORTS];
    port_t sync2_q [NUM_PORTS];
    port_t prev_q [NUM_PORTS];
    port_t out_q [NUM_PORTS];
    port_t dir_q [NUM_PORTS];
    port_t sel [NUM_PORTS];
    port_t ifg_q [IRQ_PORTS];
    port_t ies_q [IRQ_PORTS];
    port_t ie_q [IRQ_PORTS];
    port_t pend [IRQ_PORTS];

    function automatic logic hit(input idx_t a, input idx_t idx);
        return a == idx;
    endfunction : hit

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ahb-lite address phase capture, zero wait states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            rd_pend_q <= hsel && htrans[1] && !hwrite;
            if (hsel && htrans[1]) begin
                addr_q <= haddr[ADDR_MSB:ADDR_LSB];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign wdata = hwdata[PORT_W-1:0];
    assign hrdata = rd_pend_q ? {24'h000000, rd_byte} : 32'h00000000;

    // edge detection held off until the pin pipeline is filled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prime_q <= 3'h0;
        end else begin
            prime_q <= {prime_q[PRIME_W-2:0], 1'b1};
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // pin synchronisers and edge history
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[p] <= REG_RESET;
                    sync2_q[p] <= REG_RESET;
                    prev_q[p] <= REG_RESET;
                end else begin
                    sync1_q[p] <= pin_in[p];
                    sync2_q[p] <= sync1_q[p];
                    prev_q[p] <= sync2_q[p];
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    out_q[p] <= REG_RESET;
                end else if (wr_pend_q && hit(addr_q, OUT_IDX[p])) begin
                    out_q[p] <= wdata;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    dir_q[p] <= REG_RESET;
                end else if (wr_pend_q && hit(addr_q, DIR_IDX[p])) begin
                    dir_q[p] <= wdata;
                end
            end

            if (SEL_PRESENT[p]) begin : g_sel
                port_t sel_q;
                always_ff @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        sel_q <= REG_RESET;
                    end else if (wr_pend_q && hit(addr_q, SEL_IDX[p])) begin
                        sel_q <= wdata;
                    end
                end
                assign sel[p] = sel_q;
            end else begin : g_nosel
                assign sel[p] = REG_RESET;
            end

            // per bit choice of port logic or peripheral
            for (genvar b = 0; b < PORT_W; b++) begin : g_bit
                assign pin_out[p][b] = sel[p][b] ? periph_out[p][b] : out_q[p][b];
                assign pin_oe_n[p][b] = sel[p][b] ? !periph_drive[p][b] : !dir_q[p][b];
            end
            assign periph_in[p] = sync2_q[p];
        end

        for (p = 0; p < IRQ_PORTS; p++) begin : g_irq
            port_t rise;
            port_t fall;
            port_t ev;
            port_t clr;
            port_t ie_wr;
            port_t ie_val;
            assign rise = sync2_q[p] & ~prev_q[p];
            assign fall = ~sync2_q[p] & prev_q[p];
            assign ev = prime_q[PRIME_W-1] ? ((ies_q[p] & fall) | (~ies_q[p] & rise)) : REG_RESET;

            // write one to clear; low pins of port zero via the special area
            if (p == 0) begin : g_sfa
                assign clr = ({8{wr_pend_q && hit(addr_q, IFG_IDX[p])}} & wdata & OWN_MASK[p])
                    | {6'h00, {2{wr_pend_q && hit(addr_q, SFA_IFG_IDX)}} & wdata[SFA_P0_MSB:SFA_P0_LSB]};
                assign ie_wr = ({8{wr_pend_q && hit(addr_q, IE_IDX[p])}} & OWN_MASK[p])
                    | {6'h00, {2{wr_pend_q && hit(addr_q, SFA_IE_IDX)}}};
                assign ie_val = (wdata & OWN_MASK[p]) | {6'h00, wdata[SFA_P0_MSB:SFA_P0_LSB]};
            end else begin : g_own
                assign clr = {8{wr_pend_q && hit(addr_q, IFG_IDX[p])}} & wdata;
                assign ie_wr = {8{wr_pend_q && hit(addr_q, IE_IDX[p])}};
                assign ie_val = wdata;
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ifg_q[p] <= REG_RESET;
                end else begin
                    ifg_q[p] <= (ifg_q[p] & ~clr) | ev;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ies_q[p] <= REG_RESET;
                end else if (wr_pend_q && hit(addr_q, IES_IDX[p])) begin
                    ies_q[p] <= wdata;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ie_q[p] <= REG_RESET;
                end else begin
                    ie_q[p] <= (ie_q[p] & ~ie_wr) | (ie_val & ie_wr);
                end
            end

            assign pend[p] = ifg_q[p] & ie_q[p];
        end
    endgenerate

    // requests to the interrupt controller
    assign irq_p0_pin0 = pend[0][0];
    assign irq_p0_pin1 = pend[0][1];
    assign irq_p0_shared = |pend[0][PORT_W-1:SFA_P0_LSB];
    assign irq_p1 = |pend[1];
    assign irq_p2 = |pend[2];
    assign irq = irq_p0_pin0 | irq_p0_pin1 | irq_p0_shared | irq_p1 | irq_p2;

    // read mux, unmapped reads as zero
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (hit(addr_q, IN_IDX[i])) begin
                rd_byte = sync2_q[i];
            end
            if (hit(addr_q, OUT_IDX[i])) begin
                rd_byte = out_q[i];
            end
            if (hit(addr_q, DIR_IDX[i])) begin
                rd_byte = dir_q[i];
            end
            if (SEL_PRESENT[i] && hit(addr_q, SEL_IDX[i])) begin
                rd_byte = sel[i];
            end
        end
        for (int i = 0; i < IRQ_PORTS; i++) begin
            if (hit(addr_q, IFG_IDX[i])) begin
                rd_byte = ifg_q[i] & OWN_MASK[i];
            end
            if (hit(addr_q, IES_IDX[i])) begin
                rd_byte = ies_q[i];
            end
            if (hit(addr_q, IE_IDX[i])) begin
                rd_byte = ie_q[i] & OWN_MASK[i];
            end
        end
        if (hit(addr_q, SFA_IE_IDX)) begin
            rd_byte = {4'h0, ie_q[0][1:0], 2'h0};
        end
        if (hit(addr_q, SFA_IFG_IDX)) begin
            rd_byte = {4'h0, ifg_q[0][1:0], 2'h0};
        end
    end
endmodule : multi_port_digital_io
